/* hw/rst_seq_pkg.sv */
// constants and types for the device reset sequencer
package rst_seq_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RESET_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SEQ_STATUS    = 8'h04;

   // reset control register fields
   localparam int BIT_BROWNOUT_FLAG = 0;
   localparam int BIT_POWER_ON_FLAG = 1;
   localparam int BIT_SW_BOR_EN     = 6;

   // seq status register fields
   localparam int BIT_ST_RESET      = 0;
   localparam int BIT_ST_BOR_ACTIVE = 1;
   localparam int BIT_ST_PIN_INPUT  = 2;

   // ----------------------------------------------------------------
   // brown-out modes
   // ----------------------------------------------------------------
   localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
   localparam logic [1:0] BOR_MODE_SW    = 2'h1;
   localparam logic [1:0] BOR_MODE_NOSLP = 2'h2;
   localparam logic [1:0] BOR_MODE_HW    = 2'h3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ             = 100;
   localparam int POWERUP_TIMER_BITS           = 11;
   localparam int POWERUP_TIMER_PERIODS        = 2048;
   localparam int OST_CYCLES          = 1024;
   localparam int PLL_LOCK_US         = 2000;
   localparam int PLL_LOCK_CYCLES     = PLL_LOCK_US * CLK_MHZ;
   localparam int PIN_FILTER_NS       = 100;
   localparam int PIN_FILTER_CYCLES   = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int BOR_MIN_NS          = 200;
   localparam int BOR_MIN_CYCLES      = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_POWERUP_TIMER,
      ST_OST,
      ST_PLL,
      ST_RUN
   } seq_state_t;

endpackage

/* hw/device_reset_sequencer.sv */
// reset sources, power-up timers and reset-cause flags with a wishbone slave
//
// Behaviour
// - pin low resets, short pulses filtered
// - pin never driven by internal reset
// - pin disabled: plain digital input only
// - power-on detect produces power-on reset
// - power-on flag cleared by power-on only
// - two-bit mode selects brown-out behaviour
// - drop longer than minimum causes reset
// - held while supply below threshold
// - power-up timer runs after supply recovers
// - brown-out during timer restarts full delay
// - brown-out and timer enabled independently
// - software enable only in mode 01
// - threshold always from configuration bits
// - brown-out flag cleared on brown-out/power-on
// - mode 10 disables brown-out during sleep
// - three timers: powerup, oscillator, pll lock
// - power-up timer counts 2048 slow periods
// - timer disable bit clear enables timer
// - oscillator timer 1024 cycles, crystal modes
// - pll lock delay follows oscillator timer
`timescale 1ns/1ps

module device_reset_sequencer
   import rst_seq_pkg::*;
#(
   parameter int POWERUP_TIMER_DIV        = 3200,
   parameter int PLL_LOCK_CNT    = PLL_LOCK_CYCLES,
   parameter int FILTER_CNT      = PIN_FILTER_CYCLES,
   parameter int BOR_CNT         = BOR_MIN_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // pins and analog comparators
   input  wire logic        ext_reset_n_pin,
   output logic             ext_reset_pin_oe,
   output logic             ext_reset_pin_o,
   output logic             ext_pin_din,
   input  wire logic        supply_below_bor,
   input  wire logic        slow_osc_tick,
   input  wire logic        xtal_osc_tick,
   // configuration
   input  wire logic        ext_reset_pin_enable,
   input  wire logic [1:0]  brownout_mode_cfg,
   input  wire logic [1:0]  brownout_level_cfg,
   input  wire logic        powerup_timer_disable_n,
   input  wire logic        xtal_mode,
   input  wire logic        pll_enable,
   input  wire logic        sleep_mode,
   // outputs
   output logic             device_reset,
   output logic [1:0]       bor_level_sel,
   output logic             bor_detector_en,
   // wishbone
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   output logic             wb_err_o
);

   localparam int FW  = $clog2(FILTER_CNT + 1);
   localparam int BW  = $clog2(BOR_CNT + 1);
   localparam int DW  = $clog2(POWERUP_TIMER_DIV + 1);
   localparam int LW  = $clog2(PLL_LOCK_CNT + 1);
   localparam int OW  = $clog2(OST_CYCLES + 1);

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] raw_in;
   assign raw_in = {xtal_osc_tick, slow_osc_tick, supply_below_bor, ext_reset_n_pin};

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         // pin and supply park high, ticks low to match their edge registers
         s1_q <= 4'h3;
         s2_q <= 4'h3;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
      end
   end

   logic pin_s;
   logic below_s;
   logic slow_s;
   logic xtal_s;
   assign pin_s   = s2_q[0];
   assign below_s = s2_q[1];
   assign slow_s  = s2_q[2];
   assign xtal_s  = s2_q[3];

   // edge detect on the oscillator ticks
   logic slow_d_q;
   logic xtal_d_q;
   logic slow_edge;
   logic xtal_edge;
   assign slow_edge = slow_s & ~slow_d_q;
   assign xtal_edge = xtal_s & ~xtal_d_q;

   // ----------------------------------------------------------------
   // pin noise filter
   // ----------------------------------------------------------------
   // the filtered level only moves after a stable run; glitches reset the count
   logic [FW-1:0] flt_cnt_q;
   logic          pin_flt_q;
   logic          flt_same;
   logic          flt_done;
   assign flt_same = (pin_s == pin_flt_q);
   assign flt_done = (flt_cnt_q == FW'(FILTER_CNT));

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         flt_cnt_q <= '0;
         pin_flt_q <= 1'b1;
      end else if (flt_same) begin
         flt_cnt_q <= '0;
      end else if (flt_done) begin
         flt_cnt_q <= '0;
         pin_flt_q <= pin_s;
      end else begin
         flt_cnt_q <= flt_cnt_q + FW'(1);
      end
   end

   logic pin_reset;
   assign pin_reset = ext_reset_pin_enable & ~pin_flt_q;

   // ----------------------------------------------------------------
   // brown-out enable and detection
   // ----------------------------------------------------------------
   logic sw_bor_en_q;
   logic bor_en;
   always_comb begin
      unique case (brownout_mode_cfg)
         BOR_MODE_OFF:   bor_en = 1'b0;
         BOR_MODE_SW:    bor_en = sw_bor_en_q;
         BOR_MODE_NOSLP: bor_en = ~sleep_mode;
         BOR_MODE_HW:    bor_en = 1'b1;
      endcase
   end

   // only a drop outlasting the minimum counts; it then holds until recovery
   logic [BW-1:0] bor_cnt_q;
   logic          bor_act_q;
   logic          bor_cnt_done;
   assign bor_cnt_done = (bor_cnt_q == BW'(BOR_CNT));

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         bor_cnt_q <= '0;
         bor_act_q <= 1'b0;
      end else if (!bor_en || !below_s) begin
         bor_cnt_q <= '0;
         bor_act_q <= 1'b0;
      end else if (bor_cnt_done) begin
         bor_act_q <= 1'b1;
      end else begin
         bor_cnt_q <= bor_cnt_q + BW'(1);
      end
   end

   // ----------------------------------------------------------------
   // sequencer: power-up timer, oscillator timer, pll lock
   // ----------------------------------------------------------------
   // sys_rst is the power-on detector output; everything restarts from it
   logic       src_active;
   assign src_active = pin_reset | bor_act_q;

   seq_state_t      st_q;
   logic [DW-1:0]   div_q;
   logic [POWERUP_TIMER_BITS-1:0] powerup_timer_q;
   logic [OW-1:0]   ost_q;
   logic [LW-1:0]   pll_q;
   logic            por_seen_q;
   logic            div_wrap;
   logic            powerup_timer_done;
   logic            ost_done;
   logic            pll_done;
   assign div_wrap  = (div_q == DW'(POWERUP_TIMER_DIV - 1)) & slow_edge;
   assign powerup_timer_done = div_wrap & (powerup_timer_q == POWERUP_TIMER_BITS'(POWERUP_TIMER_PERIODS - 1));
   assign ost_done  = xtal_edge & (ost_q == OW'(OST_CYCLES - 1));
   assign pll_done  = (pll_q == LW'(PLL_LOCK_CNT - 1));

   // slow oscillator is modelled as a tick; the divider turns POWERUP_TIMER_DIV ticks into one period
   logic powerup_timer_skip;
   assign powerup_timer_skip = powerup_timer_disable_n;

   seq_state_t after_powerup_timer;
   seq_state_t after_ost;
   assign after_ost  = pll_enable ? ST_PLL : ST_RUN;
   assign after_powerup_timer = xtal_mode ? ST_OST : after_ost;

   // edge registers share the tick reset level, so no false edge after reset
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         slow_d_q <= 1'b0;
         xtal_d_q <= 1'b0;
      end else begin
         slow_d_q <= slow_s;
         xtal_d_q <= xtal_s;
      end
   end

   // ----------------------------------------------------------------
   // timer counters
   // ----------------------------------------------------------------
   // any source or hold wipes every timer, so a new drop reruns the full delay
   logic timers_clr;
   logic run_powerup_timer;
   logic run_ost;
   logic run_pll;
   assign timers_clr = (st_q == ST_HOLD) | src_active;
   assign run_powerup_timer   = (st_q == ST_POWERUP_TIMER);
   assign run_ost    = (st_q == ST_OST);
   assign run_pll    = (st_q == ST_PLL);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= '0;
      end else if (timers_clr) begin
         div_q <= '0;
      end else if (run_powerup_timer && slow_edge) begin
         div_q <= div_wrap ? '0 : div_q + DW'(1);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         powerup_timer_q <= '0;
      end else if (timers_clr) begin
         powerup_timer_q <= '0;
      end else if (run_powerup_timer && div_wrap) begin
         powerup_timer_q <= powerup_timer_q + POWERUP_TIMER_BITS'(1);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ost_q <= '0;
      end else if (timers_clr) begin
         ost_q <= '0;
      end else if (run_ost && xtal_edge) begin
         ost_q <= ost_q + OW'(1);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pll_q <= '0;
      end else if (timers_clr) begin
         pll_q <= '0;
      end else if (run_pll) begin
         pll_q <= pll_q + LW'(1);
      end
   end

   // each stage leaves only on its own done; a source drops back to hold
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ST_HOLD;
      end else if (src_active) begin
         st_q <= ST_HOLD;
      end else begin
         unique case (st_q)
            ST_HOLD: st_q <= powerup_timer_skip ? after_powerup_timer : ST_POWERUP_TIMER;
            ST_POWERUP_TIMER: st_q <= powerup_timer_done ? after_powerup_timer : ST_POWERUP_TIMER;
            ST_OST:  st_q <= ost_done ? after_ost : ST_OST;
            ST_PLL:  st_q <= pll_done ? ST_RUN : ST_PLL;
            ST_RUN:  st_q <= ST_RUN;
            default: st_q <= ST_HOLD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   logic wb_req;
   logic hit_ctl;
   logic hit_st;
   logic wr_ctl;
   // answers are registered, so a request is answered one cycle after it is taken
   assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign hit_ctl = (wb_adr_i == ADDR_RESET_CONTROL);
   assign hit_st  = (wb_adr_i == ADDR_SEQ_STATUS);
   assign wr_ctl  = wb_req & wb_we_i & hit_ctl & wb_sel_i[0];

   // ----------------------------------------------------------------
   // reset-cause flags
   // ----------------------------------------------------------------
   logic por_flag_q;
   logic bor_flag_q;
   logic bor_event;
   assign bor_event = bor_act_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         por_flag_q  <= 1'b0;
         bor_flag_q  <= 1'b0;
         sw_bor_en_q <= 1'b1;
         por_seen_q  <= 1'b0;
      end else begin
         por_seen_q <= 1'b1;
         if (wr_ctl && wb_dat_i[BIT_POWER_ON_FLAG]) begin
            por_flag_q <= 1'b1;
         end
         // brown-out wins over a same-cycle software set
         if (bor_event) begin
            bor_flag_q <= 1'b0;
         end else if (wr_ctl && wb_dat_i[BIT_BROWNOUT_FLAG]) begin
            bor_flag_q <= 1'b1;
         end
         if (wr_ctl && brownout_mode_cfg == BOR_MODE_SW) begin
            sw_bor_en_q <= wb_dat_i[BIT_SW_BOR_EN];
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux and outputs
   // ----------------------------------------------------------------
   logic [31:0] ctl_word;
   logic [31:0] st_word;
   logic [31:0] rd_word;
   logic        sw_bit_vis;
   assign sw_bit_vis = sw_bor_en_q & (brownout_mode_cfg == BOR_MODE_SW);
   always_comb begin
      ctl_word = '0;
      ctl_word[BIT_POWER_ON_FLAG] = por_flag_q;
      ctl_word[BIT_BROWNOUT_FLAG] = bor_flag_q;
      ctl_word[BIT_SW_BOR_EN]     = sw_bit_vis;
      st_word = '0;
      st_word[BIT_ST_RESET]      = (st_q != ST_RUN);
      st_word[BIT_ST_BOR_ACTIVE] = bor_act_q;
      st_word[BIT_ST_PIN_INPUT]  = pin_s;
   end
   assign rd_word = hit_ctl ? ctl_word : (hit_st ? st_word : 32'h0000_0000);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o         <= 1'b0;
         wb_err_o         <= 1'b0;
         wb_dat_o         <= '0;
         device_reset     <= 1'b1;
         ext_reset_pin_oe <= 1'b0;
         ext_reset_pin_o  <= 1'b0;
         ext_pin_din      <= 1'b1;
         bor_level_sel    <= 2'h0;
         bor_detector_en  <= 1'b0;
      end else begin
         wb_ack_o         <= wb_req & (hit_ctl | hit_st);
         wb_err_o         <= wb_req & ~(hit_ctl | hit_st);
         wb_dat_o         <= wb_req ? rd_word : 32'h0000_0000;
         device_reset     <= ~por_seen_q | (st_q != ST_RUN) | src_active;
         // pin stays input-only; no internal reset ever pulls it low
         ext_reset_pin_oe <= 1'b0;
         ext_reset_pin_o  <= 1'b0;
         ext_pin_din      <= ext_reset_pin_enable ? 1'b1 : pin_s;
         bor_level_sel    <= brownout_level_cfg;
         bor_detector_en  <= bor_en;
      end
   end

endmodule

/* dv/device_reset_sequencer_monitor.sv */
// port-level checks for the reset sequencer
`timescale 1ns/1ps
module device_reset_sequencer_monitor
   import rst_seq_pkg::*;
(
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       ext_reset_n_pin,
   input wire logic       ext_reset_pin_oe,
   input wire logic       ext_reset_pin_o,
   input wire logic       ext_pin_din,
   input wire logic       supply_below_bor,
   input wire logic       ext_reset_pin_enable,
   input wire logic [1:0] brownout_mode_cfg,
   input wire logic       sleep_mode,
   input wire logic       device_reset,
   input wire logic       bor_detector_en,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       wb_err_o
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   pin_idle_a: assert property (!ext_reset_pin_oe && !ext_reset_pin_o)
      else $error("reset pin driven");
   pin_din_a: assert property ($past(ext_reset_pin_enable) |-> ext_pin_din)
      else $error("pin input not parked high");
   // sync plus filter settle well inside eight plus four cycles
   pin_reset_a: assert property ((ext_reset_pin_enable && !ext_reset_n_pin)[*8]
      |-> ##4 device_reset) else $error("held pin gave no reset");
   bor_reset_a: assert property ((supply_below_bor && bor_detector_en)[*8]
      |-> ##4 device_reset) else $error("long drop gave no reset");
   clean_rel_a: assert property ($fell(device_reset)
      |-> $past(ext_reset_n_pin || !ext_reset_pin_enable, 2)
      && !$past(supply_below_bor && bor_detector_en, 2)) else $error("release with source");
   bor_hw_a: assert property (!$past(sys_rst) && $past(brownout_mode_cfg) == BOR_MODE_HW
      |-> bor_detector_en) else $error("hw mode not enabled");
   bor_off_a: assert property (!$past(sys_rst) && $past(brownout_mode_cfg) == BOR_MODE_OFF
      |-> !bor_detector_en) else $error("off mode enabled");
   bor_sleep_a: assert property (!$past(sys_rst)
      && $past(brownout_mode_cfg) == BOR_MODE_NOSLP |-> bor_detector_en == !$past(sleep_mode))
      else $error("sleep gating wrong");
   wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      |=> wb_ack_o != wb_err_o) else $error("bus answer missing");
endmodule

/* dv/supply_pin_model.sv */
// reset pin and supply monitor model for the sequencer
`timescale 1ns/1ps
module supply_pin_model (
   input  wire logic mclk,
   input  wire logic pin_low,
   input  wire logic supply_low,
   output logic      ext_reset_n_pin,
   output logic      supply_below_bor,
   output logic      slow_osc_tick,
   output logic      xtal_osc_tick
);
   // pin has a pull-up, so released reads high
   assign ext_reset_n_pin  = !pin_low;
   assign supply_below_bor = supply_low;
   // oscillators free-run; the sequencer syncs them itself
   initial begin
      slow_osc_tick = 1'b0;
      xtal_osc_tick = 1'b0;
      forever @(posedge mclk) begin
         slow_osc_tick <= !slow_osc_tick;
         xtal_osc_tick <= !xtal_osc_tick;
      end
   end
endmodule

/* dv/device_reset_sequencer_tb.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module device_reset_sequencer_tb
   import rst_seq_pkg::*;
;
   typedef struct {logic [32:0] v; logic [31:0] m;} note_t;
   localparam int POWERUP_TIMER_C = 2 * POWERUP_TIMER_PERIODS;
   localparam int FULL_C = POWERUP_TIMER_C + 2 * OST_CYCLES + 20;
   logic        mclk, sys_rst, pin_low, supply_low, pin_en, slp, ptd_n, xtal, pll, we, cyc, stb;
   logic [1:0]  mode, lvl;
   logic [7:0]  adr, lf;
   logic [31:0] dat;
   logic [3:0]  sel;
   wire         pin_n, sup, stk, xtk, din, drst, ack, err;
   wire [31:0]  rdat;
   wire [1:0]   lvs;
   note_t       q[$];
   int          err_count = 0;
   int          compares = 0;
   int          cyc_n = 0;
   supply_pin_model pm (.mclk(mclk), .pin_low(pin_low), .supply_low(supply_low),
      .ext_reset_n_pin(pin_n), .supply_below_bor(sup), .slow_osc_tick(stk), .xtal_osc_tick(xtk));
   device_reset_sequencer #(.POWERUP_TIMER_DIV(1), .PLL_LOCK_CNT(20), .FILTER_CNT(4), .BOR_CNT(4)) uut (
      .mclk(mclk), .sys_rst(sys_rst), .ext_reset_n_pin(pin_n), .ext_reset_pin_oe(),
      .ext_reset_pin_o(), .ext_pin_din(din), .supply_below_bor(sup), .slow_osc_tick(stk),
      .xtal_osc_tick(xtk), .ext_reset_pin_enable(pin_en), .brownout_mode_cfg(mode),
      .brownout_level_cfg(lvl), .powerup_timer_disable_n(ptd_n), .xtal_mode(xtal),
      .pll_enable(pll), .sleep_mode(slp), .device_reset(drst), .bor_level_sel(lvs),
      .bor_detector_en(), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] nx(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("err_count %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic rel(output int n);
      n = 0;
      while (drst !== 1'b0) begin
         @(posedge mclk);
         n++;
      end
   endtask
   // one classic cycle; the expected answer is noted first
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e, input logic [31:0] m);
      q.push_back('{e, m});
      @(posedge mclk);
      {adr, we, dat, sel, cyc, stb} <= {a, w, d, 4'hF, 2'h3};
      do @(posedge mclk); while (!(ack || err));
      {cyc, stb} <= 2'h0;
   endtask
   always @(posedge mclk) begin : watch
      note_t n;
      if (ack || err) begin
         n = q.pop_front();
         chk({err, rdat & n.m}, n.v);
      end
   end
   always @(posedge mclk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int n;
      logic en;
      logic sw_v;
      {sys_rst, pin_low, supply_low, pin_en, slp, ptd_n, xtal, pll} = 8'h9B;
      {mode, lvl, adr, dat, sel, we, cyc, stb} = {BOR_MODE_SW, 2'h2, 47'h0};
      lf = 8'h24;
      cy(3);
      sys_rst <= 1'b0;
      rel(n);
      chk(n >= FULL_C - 4 && n <= FULL_C + 40, 1);
      wb(ADDR_RESET_CONTROL, 0, 0, 33'h40, 32'h43);
      wb(ADDR_RESET_CONTROL, 1, 32'h43, 0, 0);
      wb(ADDR_RESET_CONTROL, 1, 32'h0, 0, 0);
      wb(ADDR_RESET_CONTROL, 0, 0, 33'h03, 32'h43);
      {xtal, pll, supply_low} <= 3'h1;
      cy(30);
      chk(drst, 0);
      supply_low <= 1'b0;
      wb(ADDR_RESET_CONTROL, 1, 32'h40, 0, 0);
      supply_low <= 1'b1;
      cy(200);
      chk(drst, 1);
      wb(ADDR_RESET_CONTROL, 0, 0, 33'h42, 32'h43);
      supply_low <= 1'b0;
      cy(1000);
      supply_low <= 1'b1;
      cy(20);
      supply_low <= 1'b0;
      rel(n);
      chk(n >= POWERUP_TIMER_C - 4 && n <= POWERUP_TIMER_C + 40, 1);
      {ptd_n, pin_low} <= 2'h3;
      wb(ADDR_RESET_CONTROL, 1, 32'h43, 0, 0);
      pin_low <= 1'b0;
      cy(20);
      chk(drst, 0);
      pin_low <= 1'b1;
      cy(30);
      chk(drst, 1);
      pin_low <= 1'b0;
      rel(n);
      chk(n < 20, 1);
      wb(ADDR_RESET_CONTROL, 0, 0, 33'h43, 32'h43);
      {pin_en, pin_low} <= 2'h1;
      cy(30);
      chk({drst, din}, 0);
      wb(ADDR_SEQ_STATUS, 1, 32'hFF, 0, 32'h4);
      {pin_en, pin_low} <= 2'h2;
      for (int i = 0; i < 8; i++) begin
         {mode, slp, lvl} <= {i[1:0], i[2], lf[2:1]};
         wb(ADDR_RESET_CONTROL, 1, {24'h0, lf} | 32'h3, 0, 0);
         sw_v = i[1:0] == BOR_MODE_SW && lf[6];
         en = i[1:0] == BOR_MODE_HW || (i[1:0] == BOR_MODE_NOSLP && !i[2]) || sw_v;
         wb(ADDR_RESET_CONTROL, 0, 0, {26'h0, sw_v, 6'h3}, 32'h43);
         supply_low <= 1'b1;
         cy(30);
         chk(drst, en);
         chk(lvs, lvl);
         wb(ADDR_SEQ_STATUS, 0, 0, {31'h0, en, en}, 32'h3);
         supply_low <= 1'b0;
         rel(n);
         wb(lf | 8'h08, lf[0], 0, 33'h100000000, 0);
         lf = nx(lf);
      end
      finish_test();
   end
endmodule
bind device_reset_sequencer device_reset_sequencer_monitor mon (
   .mclk(mclk), .sys_rst(sys_rst), .ext_reset_n_pin(ext_reset_n_pin),
   .ext_reset_pin_oe(ext_reset_pin_oe), .ext_reset_pin_o(ext_reset_pin_o),
   .ext_pin_din(ext_pin_din), .supply_below_bor(supply_below_bor),
   .ext_reset_pin_enable(ext_reset_pin_enable), .brownout_mode_cfg(brownout_mode_cfg),
   .sleep_mode(sleep_mode), .device_reset(device_reset), .bor_detector_en(bor_detector_en),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
